// ===== core/isasf_defs.svh
// Register offsets, field positions and reset values of the start filter
`ifndef ISASF_DEFS_SVH
`define ISASF_DEFS_SVH

`define ISASF_SFR_SETUP   8'hdb
`define ISASF_SFR_OWN_ID  8'hdf
`define ISASF_RST_BYTE    8'h00
`define ISASF_RST_FIELD   7'h00
`define ISASF_SS_EN_BIT   7
`define ISASF_CNT_MSB     6
`define ISASF_ID_MSB      7
`define ISASF_ID_LSB      1
`define ISASF_ADDR_BITS   3'h7
`define ISASF_BIT_ZERO    3'h0
`define ISASF_SYNC_IDLE   3'h7

`endif

// ===== core/isasf_pkg.sv
// Types shared by the start filter files
package isasf_pkg;

  typedef enum logic [1:0] {
    ISASF_IDLE,
    ISASF_SAMPLE,
    ISASF_ADDR
  } isasf_state_t;

endpackage

// ===== core/isasf_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "isasf_defs.svh"

module isasf_sync3 (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [2:0] async_in,
  output logic      [2:0] level_out
);

  logic [2:0] stage1_r;
  logic [2:0] stage2_r;
  logic [2:0] stage3_r;
  logic [2:0] level_r;
  wire  [2:0] agree = ~(stage2_r ^ stage3_r);
  wire  [2:0] level_nxt = (agree & stage3_r) | (~agree & level_r);

  // Lines idle high, so reset to the idle level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1_r <= `ISASF_SYNC_IDLE;
      stage2_r <= `ISASF_SYNC_IDLE;
      stage3_r <= `ISASF_SYNC_IDLE;
      level_r  <= `ISASF_SYNC_IDLE;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r  <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule
`default_nettype wire

// ===== core/isasf_start_filter.sv
// Slave address match and START validation filter
//
// What this block does
// - In slave mode the 7 address bits received after a START are compared with the own id.
// - A full 7-bit match sets both the event pending flag and the slave hit flag.
// - The engine never writes the own id register and ignores it in master mode, except for a last address bit in the cycle slave_mode falls.
// - The own id register keeps the address in bits 7:1 and bit 0 is unused.
// - In slave mode an SDA fall while SCL is high starts a possible START.
// - The START is accepted only if every sample sees SDA low and SCL high.
// - Address bits are taken only after the START has been validated.
// - With multi-sample off exactly one sample is taken, one clock after the SDA fall.
// - With multi-sample on the sample count field selects how many samples are taken.
// - The setup register has the multi-sample enable at bit 7 and the count at bits 6:0.
// - Samples are spaced by one core clock, starting after the detected SDA fall.
// - Own id sits at DFh, setup at DBh, and both reset to 00h.
// - With multi-sample on a count value n gives n+1 samples, from 1 up to 128.
`timescale 1ns/1ps
`default_nettype none
`include "isasf_defs.svh"

module isasf_start_filter (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       scl_link_clk,
  input  wire logic       sda_in,
  input  wire logic       scl_in,
  input  wire logic       slave_mode,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       event_pending_clr,
  input  wire logic       slave_hit_clr,
  output logic            event_pending_flag,
  output logic            slave_hit_flag,
  output logic            start_valid_pulse
);

  // Link side: address shifter on SCL rising edges
  logic       rst_link_s1_r;
  logic       rst_link_s2_r;
  logic [6:0] link_shift_r;
  logic       link_toggle_r;

  // Reset is carried into the link domain; it needs SCL edges while held
  always_ff @(posedge scl_link_clk) begin
    rst_link_s1_r <= rst;
    rst_link_s2_r <= rst_link_s1_r;
  end

  always_ff @(posedge scl_link_clk) begin
    if (rst_link_s2_r) begin
      link_shift_r  <= `ISASF_RST_FIELD;
      link_toggle_r <= 1'b0;
    end else begin
      link_shift_r  <= {link_shift_r[5:0], sda_in};
      link_toggle_r <= ~link_toggle_r;
    end
  end

  // Core side: filtered bus lines and bit event toggle
  wire [2:0] line_lvl;

  isasf_sync3 u_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .async_in  ({link_toggle_r, scl_in, sda_in}),
    .level_out (line_lvl)
  );

  wire sda_s = line_lvl[0];
  wire scl_s = line_lvl[1];
  wire tog_s = line_lvl[2];

  // Register select, shared by the read and the write decode
  function automatic logic sfr_sel(input logic [7:0] a, input logic [7:0] reg_off);
    return a == reg_off;
  endfunction

  // Registers
  logic [7:0] setup_r;
  logic [6:0] own_id_r;
  wire        wr_setup  = sfr_wr && sfr_sel(sfr_addr, `ISASF_SFR_SETUP);
  wire        wr_own_id = sfr_wr && sfr_sel(sfr_addr, `ISASF_SFR_OWN_ID);
  wire        rd_setup  = sfr_rd && sfr_sel(sfr_addr, `ISASF_SFR_SETUP);
  wire        rd_own_id = sfr_rd && sfr_sel(sfr_addr, `ISASF_SFR_OWN_ID);
  wire        ss_en     = setup_r[`ISASF_SS_EN_BIT];
  wire [6:0]  samp_cnt  = setup_r[`ISASF_CNT_MSB:0];
  wire [7:0]  own_id_rd = {own_id_r, 1'b0};
  wire [7:0]  rdata_nxt = rd_setup  ? setup_r :
                          rd_own_id ? own_id_rd : `ISASF_RST_BYTE;

  // Only the processor port writes the own id
  always_ff @(posedge core_clk) begin
    if (rst) begin
      setup_r   <= `ISASF_RST_BYTE;
      own_id_r  <= `ISASF_RST_FIELD;
      sfr_rdata <= `ISASF_RST_BYTE;
    end else begin
      if (wr_setup) begin
        setup_r <= sfr_wdata;
      end
      if (wr_own_id) begin
        own_id_r <= sfr_wdata[`ISASF_ID_MSB:`ISASF_ID_LSB];
      end
      if (sfr_rd) begin
        sfr_rdata <= rdata_nxt;
      end
    end
  end

  // START detection and validation
  isasf_pkg::isasf_state_t state_r;
  isasf_pkg::isasf_state_t state_nxt;
  logic       sda_prev_r;
  logic       tog_prev_r;
  logic [6:0] samp_left_r;
  logic [6:0] samp_left_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;

  wire sda_fall  = sda_prev_r && !sda_s && scl_s;
  wire fall_det  = (state_r == isasf_pkg::ISASF_IDLE) && sda_fall && slave_mode;
  wire line_ok   = !sda_s && scl_s;
  wire samp_pass = (state_r == isasf_pkg::ISASF_SAMPLE) && line_ok;
  wire samp_fail = (state_r == isasf_pkg::ISASF_SAMPLE) && !line_ok;
  wire samp_last = samp_pass && (samp_left_r == `ISASF_RST_FIELD);
  wire bit_evt   = (state_r == isasf_pkg::ISASF_ADDR) && (tog_s != tog_prev_r);
  wire last_bit  = bit_evt && (bit_cnt_r == (`ISASF_ADDR_BITS - 3'h1));
  // Shift data is stable between SCL rising edges, long after the toggle settles
  wire addr_hit  = last_bit && (link_shift_r == own_id_r);
  // Count n gives n+1 samples; enable off forces a single sample
  wire [6:0] samp_load = ss_en ? samp_cnt : `ISASF_RST_FIELD;

  always_comb begin
    state_nxt     = state_r;
    samp_left_nxt = samp_left_r;
    bit_cnt_nxt   = bit_cnt_r;
    case (state_r)
      isasf_pkg::ISASF_IDLE: begin
        if (fall_det) begin
          state_nxt     = isasf_pkg::ISASF_SAMPLE;
          samp_left_nxt = samp_load;
        end
      end
      isasf_pkg::ISASF_SAMPLE: begin
        if (samp_fail) begin
          state_nxt = isasf_pkg::ISASF_IDLE;
        end else if (samp_last) begin
          state_nxt   = isasf_pkg::ISASF_ADDR;
          bit_cnt_nxt = `ISASF_BIT_ZERO;
        end else begin
          samp_left_nxt = samp_left_r - 7'h01;
        end
      end
      isasf_pkg::ISASF_ADDR: begin
        if (!slave_mode || last_bit) begin
          state_nxt = isasf_pkg::ISASF_IDLE;
        end else if (bit_evt) begin
          bit_cnt_nxt = bit_cnt_r + 3'h1;
        end
      end
      default: begin
        state_nxt = isasf_pkg::ISASF_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r     <= isasf_pkg::ISASF_IDLE;
      sda_prev_r  <= 1'b1;
      tog_prev_r  <= 1'b0;
      samp_left_r <= `ISASF_RST_FIELD;
      bit_cnt_r   <= `ISASF_BIT_ZERO;
    end else begin
      state_r     <= state_nxt;
      sda_prev_r  <= sda_s;
      tog_prev_r  <= tog_s;
      samp_left_r <= samp_left_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
    end
  end

  // Flags: a hit in the clearing cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_pending_flag <= 1'b0;
      slave_hit_flag     <= 1'b0;
      start_valid_pulse  <= 1'b0;
    end else begin
      event_pending_flag <= addr_hit || (event_pending_flag && !event_pending_clr);
      slave_hit_flag     <= addr_hit || (slave_hit_flag && !slave_hit_clr);
      start_valid_pulse  <= samp_last;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [7:0] samp_taken_r;
  logic [7:0] samp_expect_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      samp_taken_r  <= 8'h00;
      samp_expect_r <= 8'h00;
    end else if (fall_det) begin
      samp_taken_r  <= 8'h00;
      samp_expect_r <= {1'b0, samp_load} + 8'h01;
    end else if (samp_pass) begin
      samp_taken_r <= samp_taken_r + 8'h01;
    end
  end

  // Sampling window
  a_single_sample: assert property (fall_det && !ss_en |=> samp_fail || samp_last)
    else $error("single sample mode took more than one sample");

  a_sample_total: assert property (samp_last |-> samp_taken_r + 8'h01 == samp_expect_r)
    else $error("sample count differs from setup value plus one");

  a_sample_load: assert property (fall_det |=> samp_left_r == $past(samp_load))
    else $error("sample counter not loaded from setup");

  a_sample_spacing: assert property (samp_pass && !samp_last |=>
      state_r == isasf_pkg::ISASF_SAMPLE && samp_left_r == $past(samp_left_r) - 7'h01)
    else $error("samples not taken on consecutive clocks");

  a_fail_discards: assert property (samp_fail |=> state_r == isasf_pkg::ISASF_IDLE
      ##1 $stable(slave_hit_flag) || !slave_hit_flag)
    else $error("failed sample did not drop the start");

  a_start_accept: assert property (samp_last |=>
      state_r == isasf_pkg::ISASF_ADDR && start_valid_pulse)
    else $error("passed samples did not enter address phase");

  a_pulse_single: assert property (start_valid_pulse |=> !start_valid_pulse)
    else $error("start valid pulse longer than one cycle");

  // Address phase and flags
  a_hit_sets_flags: assert property (addr_hit |=> event_pending_flag && slave_hit_flag)
    else $error("address match did not raise both flags");

  a_hit_needs_start: assert property ($rose(slave_hit_flag) |->
      $past(state_r) == isasf_pkg::ISASF_ADDR)
    else $error("hit flag raised outside address phase");

  a_hit_flag_quiet: assert property (!addr_hit && !slave_hit_flag |=> !slave_hit_flag)
    else $error("hit flag rose without a match");

  a_evt_flag_quiet: assert property (!addr_hit && !event_pending_flag |=>
      !event_pending_flag)
    else $error("event flag rose without a match");

  a_hit_flag_clear: assert property (slave_hit_clr && !addr_hit |=> !slave_hit_flag)
    else $error("hit flag ignored its clear");

  a_evt_flag_clear: assert property (event_pending_clr && !addr_hit |=>
      !event_pending_flag)
    else $error("event flag ignored its clear");

  // Bit events counted apart from the state machine, so a miscount shows
  logic [3:0] addr_bits_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_bits_r <= 4'h0;
    end else if (samp_last) begin
      addr_bits_r <= 4'h0;
    end else if (bit_evt) begin
      addr_bits_r <= addr_bits_r + 4'h1;
    end
  end

  a_seven_bits: assert property (addr_hit |-> addr_bits_r == {1'b0, `ISASF_ADDR_BITS} - 4'h1)
    else $error("address compared at the wrong bit");

  // Master mode
  a_master_ignores: assert property (!slave_mode && state_r == isasf_pkg::ISASF_IDLE |=>
      state_r == isasf_pkg::ISASF_IDLE)
    else $error("start taken while in master mode");

  a_master_abort: assert property (!slave_mode && state_r == isasf_pkg::ISASF_ADDR |=>
      state_r == isasf_pkg::ISASF_IDLE)
    else $error("address phase kept in master mode");

  // Register port
  a_own_id_hold: assert property (!wr_own_id |=> $stable(own_id_r))
    else $error("own id changed without a processor write");

  a_bit0_zero: assert property (rd_own_id |=> sfr_rdata[0] == 1'b0)
    else $error("unused own id bit read as one");

  // A read that meets a write returns the old value
  a_rdata_setup: assert property (rd_setup |=> sfr_rdata == $past(setup_r))
    else $error("setup register read back wrong");

  a_rdata_own_id: assert property (rd_own_id |=> sfr_rdata == {$past(own_id_r), 1'b0})
    else $error("own id register read back wrong");

  a_rdata_unmapped: assert property (sfr_rd && !rd_setup && !rd_own_id |=>
      sfr_rdata == `ISASF_RST_BYTE)
    else $error("unmapped read returned nonzero data");

  a_reset_values: assert property ($fell(rst) |-> setup_r == `ISASF_RST_BYTE
      && own_id_r == `ISASF_RST_FIELD)
    else $error("registers not zero after reset");

  // Main scenarios
  c_single_accept: cover property (fall_det && !ss_en ##1 samp_last);
  c_multi_accept:  cover property (fall_det && ss_en && samp_cnt != `ISASF_RST_FIELD
      ##[1:128] samp_last);
  c_reject:        cover property (samp_fail);
  c_hit:           cover property (addr_hit);
  c_master_block:  cover property (!slave_mode && sda_fall);

endmodule
`default_nettype wire

// ===== test/isasf_master_model.sv
// Two-wire bus master model: START, address bits, R/W bit and STOP
`timescale 1ns/1ps
`default_nettype none
module isasf_master_model (
  output var logic sda,
  output var logic scl
);
  localparam int HALF_NS = 80;
  // Lines rest high through their pull-ups between frames
  initial begin
    sda = 1'b1;
    scl = 1'b1;
  end
  // SCL pulses with SDA high, only so the link-side reset can settle
  task automatic reset_pulses(input int n);
    repeat (n) begin
      #(HALF_NS) scl = 1'b0;
      #(HALF_NS) scl = 1'b1;
    end
  endtask
  // A short hold with keep low gives the START up on purpose
  task automatic frame(input logic [6:0] addr, input int hold_ns, input bit keep);
    sda = 1'b0;
    #(hold_ns);
    if (!keep) begin
      sda = 1'b1;
    end else begin
      for (int i = 6; i >= 0; i--) begin
        scl = 1'b0;
        #(HALF_NS / 2) sda = addr[i];
        #(HALF_NS / 2) scl = 1'b1;
        #(HALF_NS);
      end
      scl = 1'b0;
      #(HALF_NS / 2) sda = 1'b0;
      #(HALF_NS / 2) scl = 1'b1;
      #(HALF_NS) sda = 1'b1;
    end
    #(4 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// ===== test/tb_i2c_slave_addr_start_filter.sv
// Self-checking bench for the start filter against a bus master model
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_addr_start_filter;
  logic       core_clk;
  logic       rst;
  logic       sda;
  logic       scl;
  logic       slave_mode;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       event_pending_clr;
  logic       slave_hit_clr;
  logic       event_pending_flag;
  logic       slave_hit_flag;
  logic       start_valid_pulse;
  int         err_count;
  int         n_compared;
  int         seed;
  int         cyc;
  int         fall_cyc;
  int         pulse_cyc;
  int         n_pulse;
  int         n;
  logic [7:0] own;
  logic [7:0] setups [8];

  isasf_start_filter uut (
    .core_clk           (core_clk),
    .rst                (rst),
    .scl_link_clk       (scl),
    .sda_in             (sda),
    .scl_in             (scl),
    .slave_mode         (slave_mode),
    .sfr_addr           (sfr_addr),
    .sfr_wr             (sfr_wr),
    .sfr_rd             (sfr_rd),
    .sfr_wdata          (sfr_wdata),
    .sfr_rdata          (sfr_rdata),
    .event_pending_clr  (event_pending_clr),
    .slave_hit_clr      (slave_hit_clr),
    .event_pending_flag (event_pending_flag),
    .slave_hit_flag     (slave_hit_flag),
    .start_valid_pulse  (start_valid_pulse)
  );
  isasf_master_model m (
    .sda (sda),
    .scl (scl)
  );

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (start_valid_pulse === 1'b1) begin
      n_pulse <= n_pulse + 1;
      pulse_cyc <= cyc;
    end
  end

  function automatic int samples(input logic [7:0] s);
    return s[7] ? int'(s[6:0]) + 1 : 1;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    check(sfr_rdata, exp);
  endtask

  // Pass holds outlast the samples by a margin, fail holds end before them
  task automatic run_frame(input logic [6:0] a, input int n, input bit keep,
                           input logic [1:0] exp_flags, input bit exp_pulse);
    int hold;
    int d;
    hold = keep ? (n + 6) * 10 : (n - 2) * 10;
    @(posedge core_clk);
    #3;
    n_pulse = 0;
    fall_cyc = cyc;
    m.frame(a, hold, keep);
    repeat (8) @(posedge core_clk);
    #1;
    d = pulse_cyc - fall_cyc;
    check({7'h00, n_pulse == 1}, {7'h00, exp_pulse});
    if (exp_pulse) check({7'h00, d >= n + 3 && d <= n + 6}, 8'h01);
    check({6'h00, event_pending_flag, slave_hit_flag}, {6'h00, exp_flags});
    @(posedge core_clk);
    event_pending_clr <= 1'b1;
    slave_hit_clr <= 1'b1;
    @(posedge core_clk);
    event_pending_clr <= 1'b0;
    slave_hit_clr <= 1'b0;
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The link reset needs SCL edges, so reset also spans three bus pulses
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    slave_mode = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    event_pending_clr = 1'b0;
    slave_hit_clr = 1'b0;
    err_count = 0;
    n_compared = 0;
    seed = 29;
    cyc = 0;
    n_pulse = 0;
    setups = '{8'h00, 8'h7f, 8'h80, 8'h81, 8'h82, 8'h8b, 8'h97, 8'hff};
    repeat (6) @(posedge core_clk);
    m.reset_pulses(3);
    @(posedge core_clk);
    rst <= 1'b0;
    // Two more SCL edges are needed before the link reset lets go
    m.reset_pulses(3);
    repeat (6) @(posedge core_clk);
    sfr_read(8'hdb, 8'h00);
    sfr_read(8'hdf, 8'h00);
    sfr_read(8'hde, 8'h00);
    $display("test reset_values done");
    foreach (setups[i]) begin
      own = $random(seed);
      n = samples(setups[i]);
      sfr_write(8'hdb, setups[i]);
      sfr_write(8'hdf, own);
      sfr_read(8'hdb, setups[i]);
      sfr_read(8'hdf, {own[7:1], 1'b0});
      run_frame(own[7:1], n, 1'b1, 2'b11, 1'b1);
      run_frame(own[7:1] ^ (7'h01 << (i % 7)), n, 1'b1, 2'b00, 1'b1);
      if (n >= 3) run_frame(own[7:1], n, 1'b0, 2'b00, 1'b0);
      $display("test setup %h done", setups[i]);
    end
    slave_mode <= 1'b0;
    run_frame(own[7:1], n, 1'b1, 2'b00, 1'b0);
    $display("test master_mode done");
    finish_test();
  end

  initial begin
    #500000;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
